/* File: vss_ctrl.v */
// valley select and soft-start control core of a quasi-resonant flyback
// assumes comparator outputs already synchronous to clk_sys_i
// assumes the switch-off request already carries its own blanking time
`timescale 1ns/1ns
`include "vss_defines.vh"

// What this block does
// [RULE1] supply-good stops charging, starts soft-start
// [RULE2] soft-start is 12 ms in 4 timed steps
// [RULE3] current limit steps 0.32 V up to 1 V
// [RULE4] digital switch-on, analog switch-off
// [RULE5] up/down counter holds turn-on valley index
// [RULE6] feedback judged every 48 ms period
// [RULE7] always below low: count up to 7
// [RULE8] above low only: hold value
// [RULE9] above high only: count down to 1
// [RULE10] above reset threshold: force to 1
// [RULE11] counter stays within 1 to 7
// [RULE12] counter starts at 1
// [RULE13] thresholds shift with line voltage
// [RULE14] valley count 0..7, clears on gate high
// [RULE15] turn on when valleys reach counter
// [RULE16] max off time forces turn-on
// [RULE17] soft-start steps are equal quarters
// [RULE18] threshold flags sticky per period
module vss_ctrl #(
    parameter STEP_CYCLES = `VSS_STEP_CYCLES,
    parameter PERIOD_CYCLES = `VSS_PERIOD_CYCLES,
    parameter OFFMAX_CYCLES = `VSS_OFFMAX_CYCLES,
    parameter RING_CYCLES = `VSS_RING_CYCLES
) (
    input wire clk_sys_i,
    input wire reset_i,
    input wire supply_on_i,
    input wire valley_sense_pin_i,
    input wire fb_above_up_i,
    input wire fb_above_down_i,
    input wire fb_above_reset_i,
    input wire high_line_i,
    input wire cs_off_i,
    output reg startup_charge_en_o,
    output reg [9:0] cs_limit_mv_o,
    output reg [1:0] softstart_step_o,
    output reg softstart_done_o,
    output reg line_threshold_sel_o,
    output reg gate_o,
    output wire [2:0] valley_target_o,
    output reg [2:0] valley_count_o
);

// sequencer states
localparam ST_OFF = 2'h0;
localparam ST_SOFT = 2'h1;
localparam ST_RUN = 2'h2;
// top of the valley counter
localparam VALLEY_MAX = 3'h7;

// state and counters
reg [1:0] state_r;
reg [31:0] step_cnt_r;
reg [31:0] off_cnt_r;
reg zc_prev_r;
// decoded conditions
wire running;
wire zc_fall;
wire ring_done;
wire offmax_hit;
wire turn_on;
wire turn_off;

// soft-start limit for a step index
function [9:0] step_limit;
    input [1:0] idx;
    begin
        case (idx)
            2'h0: step_limit = `VSS_LIMIT_STEP0;
            2'h1: step_limit = `VSS_LIMIT_STEP1;
            2'h2: step_limit = `VSS_LIMIT_STEP2;
            default: step_limit = `VSS_LIMIT_STEP3;
        endcase
    end
endfunction

// any state but off means the converter is switching
assign running = (state_r != ST_OFF);

// ----------------------------------------
// start-up and soft-start sequencer
// ----------------------------------------
always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
        state_r <= ST_OFF;
        step_cnt_r <= 32'h0;
        startup_charge_en_o <= 1'b1;
        softstart_step_o <= 2'h0;
        softstart_done_o <= 1'b0;
        cs_limit_mv_o <= `VSS_LIMIT_STEP0;
    end else begin
        case (state_r)
            ST_OFF: begin
                startup_charge_en_o <= 1'b1;
                if (supply_on_i) begin
                    state_r <= ST_SOFT;
                    startup_charge_en_o <= 1'b0; // [RULE1]
                    step_cnt_r <= 32'h0;
                    softstart_step_o <= 2'h0;
                    cs_limit_mv_o <= step_limit(2'h0); // [RULE3]
                end
            end
            ST_SOFT: begin
                // every step holds for STEP_CYCLES clocks
                if (step_cnt_r == STEP_CYCLES - 1) begin
                    step_cnt_r <= 32'h0; // [RULE17]
                    if (softstart_step_o == 2'h3) begin
                        state_r <= ST_RUN; // [RULE2]
                        softstart_done_o <= 1'b1;
                    end else begin
                        softstart_step_o <= softstart_step_o + 2'h1;
                        cs_limit_mv_o <= step_limit(softstart_step_o + 2'h1); // [RULE3]
                    end
                end else begin
                    step_cnt_r <= step_cnt_r + 32'h1;
                end
            end
            ST_RUN: begin
                cs_limit_mv_o <= `VSS_LIMIT_STEP3;
            end
            default: state_r <= ST_OFF;
        endcase
        // losing the supply overrides any step in progress
        if (!supply_on_i && running) begin
            state_r <= ST_OFF; // supply lost: back to charging
            startup_charge_en_o <= 1'b1;
            softstart_done_o <= 1'b0;
            softstart_step_o <= 2'h0;
            cs_limit_mv_o <= `VSS_LIMIT_STEP0;
        end
    end
end

// ----------------------------------------
// line-dependent threshold select
// ----------------------------------------
// line level picks the threshold pair used by the feedback comparators
always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i)
        line_threshold_sel_o <= 1'b0;
    else
        line_threshold_sel_o <= high_line_i; // [RULE13]
end

// ----------------------------------------
// up/down valley counter
// ----------------------------------------
// one decision per feedback period; sticky flags live inside
vss_updown #(
    .PERIOD_CYCLES(PERIOD_CYCLES)
) u_updown (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .run_i(running),
    .above_up_i(fb_above_up_i),
    .above_down_i(fb_above_down_i),
    .above_reset_i(fb_above_reset_i),
    .valley_o(valley_target_o), // [RULE5]
    .period_end_o()
);

// ----------------------------------------
// valley counting and gate control
// ----------------------------------------
// switch-on and switch-off decisions
assign zc_fall = zc_prev_r && !valley_sense_pin_i;
assign ring_done = (off_cnt_r >= RING_CYCLES);
assign offmax_hit = (off_cnt_r >= OFFMAX_CYCLES - 1); // [RULE16] longest off time reached
assign turn_on = ring_done && (valley_count_o >= valley_target_o); // [RULE15]
assign turn_off = gate_o && cs_off_i; // analog side ends the on-time

// previous level of the valley sense input; low after reset so no false edge
always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i)
        zc_prev_r <= 1'b0;
    else if (!running)
        zc_prev_r <= 1'b0;
    else
        zc_prev_r <= valley_sense_pin_i;
end

// off-time counter: cleared while the gate is high, counts while it is low
always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i)
        off_cnt_r <= 32'h0;
    else if (!running || gate_o)
        off_cnt_r <= 32'h0;
    else
        off_cnt_r <= off_cnt_r + 32'h1;
end

// valley counter: falling crossings while off, saturating, cleared at turn-on
always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
        valley_count_o <= 3'h0;
    end else if (!running) begin
        valley_count_o <= 3'h0;
    end else if (!gate_o) begin
        if (turn_on || offmax_hit)
            valley_count_o <= 3'h0; // [RULE14]
        else if (zc_fall && valley_count_o != VALLEY_MAX)
            valley_count_o <= valley_count_o + 3'h1; // [RULE14]
    end
end

// gate drive: switch-on is digital, switch-off follows the analog request
always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i)
        gate_o <= 1'b0;
    else if (!running)
        gate_o <= 1'b0;
    else if (turn_off)
        gate_o <= 1'b0; // [RULE4] analog decides off
    else if (!gate_o && (turn_on || offmax_hit))
        gate_o <= 1'b1; // [RULE4] [RULE15] [RULE16]
end

endmodule

/* File: vss_defines.vh */
// constants for the valley select and soft-start control core
// assumes a 100 MHz system clock; times are in microseconds
`ifndef VSS_DEFINES_VH
`define VSS_DEFINES_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define VSS_CLK_MHZ 100
`define VSS_SOFTSTART_US 12000
`define VSS_SOFTSTART_STEPS 4
`define VSS_STEP_CYCLES ((`VSS_SOFTSTART_US / `VSS_SOFTSTART_STEPS) * `VSS_CLK_MHZ)
`define VSS_PERIOD_US 48000
`define VSS_PERIOD_CYCLES (`VSS_PERIOD_US * `VSS_CLK_MHZ)
`define VSS_OFFMAX_US 50
`define VSS_OFFMAX_CYCLES (`VSS_OFFMAX_US * `VSS_CLK_MHZ)
`define VSS_RING_US 2
`define VSS_RING_CYCLES (`VSS_RING_US * `VSS_CLK_MHZ)

// ----------------------------------------
// counter limits and soft-start limit codes (millivolts)
// ----------------------------------------
`define VSS_UD_MIN 3'h1
`define VSS_UD_MAX 3'h7
`define VSS_LIMIT_STEP0 10'h140
`define VSS_LIMIT_STEP1 10'h1f5
`define VSS_LIMIT_STEP2 10'h2aa
`define VSS_LIMIT_STEP3 10'h3e8

`endif

/* File: vss_updown.v */
// up/down valley counter with sticky threshold flags per period
// assumes comparator inputs synchronous to clk_sys_i
`timescale 1ns/1ns
`include "vss_defines.vh"

module vss_updown #(
    parameter PERIOD_CYCLES = `VSS_PERIOD_CYCLES
) (
    input wire clk_sys_i,
    input wire reset_i,
    input wire run_i,
    input wire above_up_i,
    input wire above_down_i,
    input wire above_reset_i,
    output reg [2:0] valley_o,
    output reg period_end_o
);

reg [31:0] per_cnt_r;
reg seen_up_r;
reg seen_down_r;
reg seen_reset_r;
wire tick;

assign tick = run_i && (per_cnt_r == PERIOD_CYCLES - 1);

// ----------------------------------------
// period timer, flags and counter update
// ----------------------------------------
always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
        per_cnt_r <= 32'h0;
        seen_up_r <= 1'b0;
        seen_down_r <= 1'b0;
        seen_reset_r <= 1'b0;
        valley_o <= `VSS_UD_MIN;
        period_end_o <= 1'b0;
    end else if (!run_i) begin
        per_cnt_r <= 32'h0;
        seen_up_r <= 1'b0;
        seen_down_r <= 1'b0;
        seen_reset_r <= 1'b0;
        valley_o <= `VSS_UD_MIN; // [RULE12]
        period_end_o <= 1'b0;
    end else begin
        period_end_o <= tick;
        if (tick) begin
            per_cnt_r <= 32'h0;
            // last-cycle samples fold into the decision; flags then clear [RULE18]
            if (seen_reset_r || above_reset_i)
                valley_o <= `VSS_UD_MIN; // [RULE10]
            else if (seen_down_r || above_down_i) begin
                if (valley_o != `VSS_UD_MIN)
                    valley_o <= valley_o - 3'h1; // [RULE9] [RULE11]
            end else if (seen_up_r || above_up_i)
                valley_o <= valley_o; // [RULE8]
            else if (valley_o != `VSS_UD_MAX)
                valley_o <= valley_o + 3'h1; // [RULE7] [RULE11]
            seen_up_r <= 1'b0;
            seen_down_r <= 1'b0;
            seen_reset_r <= 1'b0;
        end else begin
            per_cnt_r <= per_cnt_r + 32'h1; // [RULE6]
            seen_up_r <= seen_up_r | above_up_i; // [RULE18]
            seen_down_r <= seen_down_r | above_down_i;
            seen_reset_r <= seen_reset_r | above_reset_i;
        end
    end
end

endmodule

/* File: vss_ctrl_monitor.sv */
// checker for the valley select and soft-start core
// assumes it is bound to every vss_ctrl instance
`timescale 1ns/1ns
module vss_ctrl_mon #(
    parameter OFFMAX_CYCLES = 100,
    parameter RING_CYCLES = 5
) (
    input wire clk_sys_i,
    input wire reset_i,
    input wire supply_on_i,
    input wire cs_off_i,
    input wire startup_charge_en_o,
    input wire [1:0] softstart_step_o,
    input wire gate_o,
    input wire [2:0] valley_target_o,
    input wire [2:0] valley_count_o
);
    reg [15:0] off_cnt_r;
    // cycles the gate has been off while supply_on_i is high
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) off_cnt_r <= 16'h0;
        else if (gate_o || !supply_on_i) off_cnt_r <= 16'h0;
        else off_cnt_r <= off_cnt_r + 16'h1;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // ----
    // assertions
    // ----
    charge_off_a: assert property ($rose(supply_on_i) |-> ##[1:2] !startup_charge_en_o)
        else $error("charge path still on");
    target_step_a: assert property ($changed(valley_target_o) |->
        valley_target_o == $past(valley_target_o) + 3'h1 || valley_target_o == $past(valley_target_o) - 3'h1
        || valley_target_o == 3'h1) else $error("valley target jumped");
    target_hold_a: assert property ($changed(valley_target_o) |=> $stable(valley_target_o)[*8])
        else $error("valley target changed inside a period");
    count_clear_a: assert property ($rose(gate_o) |-> valley_count_o == 3'h0)
        else $error("valley count not cleared");
    gate_valley_a: assert property ($rose(gate_o) && $past(off_cnt_r) < OFFMAX_CYCLES - 3 |->
        $past(valley_count_o) >= $past(valley_target_o) && $past(off_cnt_r) >= RING_CYCLES - 2)
        else $error("gate on too early");
    off_max_a: assert property (off_cnt_r <= OFFMAX_CYCLES + 2)
        else $error("gate off too long");
    cs_off_a: assert property (gate_o && cs_off_i |=> !gate_o)
        else $error("gate ignored switch-off");
    step_hold_a: assert property ($changed(softstart_step_o) && softstart_step_o != 2'h0 |=>
        $stable(softstart_step_o)[*8]) else $error("soft-start step too short");
    cover property ($rose(gate_o));
    cover property ($fell(valley_target_o));
    cover property ($rose(softstart_step_o == 2'h3));
endmodule
bind vss_ctrl vss_ctrl_mon #(.OFFMAX_CYCLES(OFFMAX_CYCLES), .RING_CYCLES(RING_CYCLES)) u_mon (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .supply_on_i(supply_on_i), .cs_off_i(cs_off_i),
    .startup_charge_en_o(startup_charge_en_o), .softstart_step_o(softstart_step_o), .gate_o(gate_o),
    .valley_target_o(valley_target_o), .valley_count_o(valley_count_o));

/* File: vss_plant.sv */
// model of the comparators and switch around the core
// assumes the gate drive changes on clk_i edges
`timescale 1ns/1ns
module vss_plant (
    input wire clk_i,
    input wire gate_i,
    input wire ring_en_i,
    output reg valley_o = 1'b0,
    output reg cs_off_o = 1'b0
);
    reg [3:0] ph_r = 4'h0;
    reg gate_d_r = 1'b0;
    // ringing gives a falling crossing every 4 cycles; damped line stays low
    always @(posedge clk_i) begin
        gate_d_r <= gate_i;
        ph_r <= (gate_i != gate_d_r) ? 4'h0 : ph_r + 4'h1;
        valley_o <= !gate_i && ring_en_i && !ph_r[1];
        cs_off_o <= gate_i && gate_d_r && (ph_r >= 4'h2); // fresh on-time only
    end
endmodule

/* File: tb_top.sv */
// self-checking bench for the valley select and soft-start core
// assumes the plant model and checker are compiled first
`timescale 1ns/1ns
module tb_top;
    reg clk_sys_i = 1'b0;
    reg reset_i = 1'b1;
    reg supply_on_i = 1'b0;
    reg high_line_i = 1'b0;
    reg ring_en = 1'b1;
    reg [1:0] fb_lvl = 2'h0;
    reg [39:0] lims = {10'h3e8, 10'h2aa, 10'h1f5, 10'h140};
    reg [2:0] last_cnt;
    wire vsense, cs_off, charge_en, done, line_sel, gate;
    wire [9:0] limit;
    wire [1:0] step;
    wire [2:0] target, count;
    integer miscompares = 0;
    integer samples_checked = 0;
    integer n;
    vss_ctrl #(.STEP_CYCLES(20), .PERIOD_CYCLES(50), .OFFMAX_CYCLES(100), .RING_CYCLES(5)) uut (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .supply_on_i(supply_on_i), .valley_sense_pin_i(vsense),
        .fb_above_up_i(fb_lvl != 2'h0), .fb_above_down_i(fb_lvl[1]), .fb_above_reset_i(fb_lvl == 2'h3),
        .high_line_i(high_line_i), .cs_off_i(cs_off), .startup_charge_en_o(charge_en), .cs_limit_mv_o(limit),
        .softstart_step_o(step), .softstart_done_o(done), .line_threshold_sel_o(line_sel), .gate_o(gate),
        .valley_target_o(target), .valley_count_o(count));
    vss_plant u_plant (.clk_i(clk_sys_i), .gate_i(gate), .ring_en_i(ring_en), .valley_o(vsense), .cs_off_o(cs_off));
    // 100 MHz clock
    initial forever #5 clk_sys_i = ~clk_sys_i;
    task chk(input [15:0] got, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer k);
        begin
            repeat (k) @(posedge clk_sys_i);
            #1;
        end
    endtask
    task per_step(input [1:0] lvl, input [2:0] exp);
        begin
            tick(19);
            @(posedge clk_sys_i) fb_lvl <= lvl;
            @(posedge clk_sys_i) fb_lvl <= 2'h0;
            tick(29);
            chk(target, exp);
        end
    endtask
    task t_soft;
        begin
            @(posedge clk_sys_i) supply_on_i <= 1'b1;
            tick(2);
            chk(charge_en, 16'h0);
            tick(8);
            for (n = 0; n < 4; n = n + 1) begin
                chk({done, step, limit}, {1'b0, n[1:0], lims[n*10 +: 10]});
                tick(20);
            end
            chk(done, 16'h1);
        end
    endtask
    task t_count;
        begin
            chk(target, 16'h2);
            n = 0;
            while (target === 3'h2 && n < 60) begin tick(1); n = n + 1; end
            chk(target, 16'h3);
            for (n = 4; n < 8; n = n + 1) per_step(2'h0, n[2:0]);
            per_step(2'h0, 3'h7);
            per_step(2'h1, 3'h7);
            per_step(2'h2, 3'h6);
            per_step(2'h3, 3'h1);
            per_step(2'h2, 3'h1);
            per_step(2'h0, 3'h2);
        end
    endtask
    task off_time;
        begin
            n = 0;
            while (gate !== 1'b1 && n < 300) begin tick(1); n = n + 1; end
            n = 0;
            while (gate !== 1'b0 && n < 300) begin tick(1); n = n + 1; end
            n = 0;
            while (gate !== 1'b1 && n < 300) begin last_cnt = count; tick(1); n = n + 1; end
        end
    endtask
    task t_gate;
        begin
            @(posedge clk_sys_i) fb_lvl <= 2'h1; // hold the valley target steady
            off_time;
            chk(last_cnt >= target, 16'h1);
            chk(count, 16'h0);
            chk(n < 98, 16'h1);
            @(posedge clk_sys_i) ring_en <= 1'b0;
            off_time;
            chk(n >= 98 && n <= 101, 16'h1);
        end
    endtask
    task t_tail;
        begin
            chk(line_sel, 16'h0);
            @(posedge clk_sys_i) high_line_i <= 1'b1;
            tick(2);
            chk(line_sel, 16'h1);
            @(posedge clk_sys_i) supply_on_i <= 1'b0;
            tick(3);
            chk({charge_en, gate, target}, 16'h11);
        end
    endtask
    task stop_test;
        begin
            if (miscompares == 0 && samples_checked > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        tick(2);
        chk({charge_en, target, count, gate}, 16'h90);
        chk(limit, 16'h140);
        t_soft;
        t_count;
        t_gate;
        t_tail;
        stop_test;
    end
    // watchdog
    initial begin
        #40000;
        miscompares = miscompares + 1;
        stop_test;
    end
endmodule
